// ---- hdl/serial_clk_gen.sv ----
// serial port bit clock generator with loopback and receive clock routing
`include "serial_clk_cfg.svh"
// Contract
// - two select bits choose generator input clock
// - bit clock is input divided by field+1
// - preloaded divider counter makes the bit clock
// - odd divide gives 50% duty, zero follows input duty
// - even divide 2p: high p+1, low p
// - edge select picks external clock edge
// - without resync the divider runs freely
// - frame edge restarts divider, makes frame pulse
// - bit clock restarts high after resync
// - frame sampled on the generating clock edge
// - resync ignores frame period input
// - transmitter follows generator clock and frame
// - no loopback during clock stop modes
// - loopback routes transmit signals to receive
// - loopback forces transmit clock/frame outputs
// - receive clock input, polarity inverted
// - bit clock drives receiver and pin
// - loopback mode0: receive pin high impedance
// - loopback mode1: pin outputs transmit clock
// - internal input is processor clock over six
module serial_clk_gen #(
  parameter int INT_DIV = `INT_CLK_DIV  // processor clocks per internal input period
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR,
  // serial pins
  input  wire logic        I_DEDICATED_EXT_CLOCK_PIN,
  input  wire logic        I_RECEIVE_CLOCK_PIN,
  output logic             O_RECEIVE_CLOCK_PIN,
  output logic             O_RECEIVE_CLOCK_PIN_OE,
  input  wire logic        I_TRANSMIT_CLOCK_PIN,
  output logic             O_TRANSMIT_CLOCK_PIN,
  output logic             O_TRANSMIT_CLOCK_PIN_OE,
  input  wire logic        I_RECEIVE_FRAME_PIN,
  output logic             O_RECEIVE_FRAME_PIN,
  output logic             O_RECEIVE_FRAME_PIN_OE,
  input  wire logic        I_TRANSMIT_FRAME_PIN,
  output logic             O_TRANSMIT_FRAME_PIN,
  output logic             O_TRANSMIT_FRAME_PIN_OE,
  input  wire logic        I_RECEIVE_DATA_PIN,
  output logic             O_TRANSMIT_DATA_PIN,
  // transmitter and frame counter side
  input  wire logic        I_TX_DATA,
  input  wire logic        I_TX_FRAME,
  input  wire logic        I_FRAME_REQ,
  // generator and receiver side
  output logic             O_GENERATED_BIT_CLOCK,
  output logic             O_GENERATED_FRAME_PULSE,
  output logic             O_INTERNAL_RECEIVE_CLOCK,
  output logic             O_INTERNAL_TRANSMIT_CLOCK,
  output logic             O_RX_FRAME,
  output logic             O_RX_DATA
);

  // refuse an internal divider that cannot make two phases
  if (INT_DIV < 2) begin : g_bad_div
    $error("INT_DIV must be at least 2");
  end

  localparam int IW = $clog2(INT_DIV);  // internal divider width

  // control register and its field view
  logic [31:0]           ctrl_word;        // software control word
  serial_clk_pkg::ctrl_t cfg;              // field view of the word
  logic [31:0]           next_ctrl;        // control word after a write
  logic [31:0]           wr_merge;         // write data merged by lanes
  logic [31:0]           stat_word;        // status read value
  logic [31:0]           next_prdata;      // read data for the access phase

  assign cfg = serial_clk_pkg::ctrl_t'(ctrl_word[`CTRL_W-1:0]);

  // apb decode: a setup cycle arms ready for the following access cycle
  wire setup    = I_PSEL & ~I_PENABLE;
  wire access   = I_PSEL & I_PENABLE & O_PREADY;
  wire hit_ctrl = I_PADDR == `CTRL_OFS;
  wire hit_stat = I_PADDR == `STAT_OFS;
  // status is read only, so a write to it is refused like a miss
  wire bad_addr = ~(hit_ctrl | (hit_stat & ~I_PWRITE));
  wire wr_ctrl  = access & I_PWRITE & hit_ctrl;

  // byte lane merge, lanes without a strobe keep their old value
  always_comb begin
    wr_merge = ctrl_word;
    for (int b = 0; b < 4; b++) begin
      if (I_PSTRB[b]) begin
        wr_merge[8*b +: 8] = I_PWDATA[8*b +: 8];
      end
    end
  end

  assign next_ctrl   = wr_ctrl ? (wr_merge & `CTRL_MASK) : ctrl_word;
  assign next_prdata = (setup & ~I_PWRITE & hit_ctrl) ? ctrl_word :
                       (setup & ~I_PWRITE & hit_stat) ? stat_word : O_PRDATA;

  // bus slave registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_word <= `CTRL_RST;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
    end else begin
      ctrl_word <= next_ctrl;
      O_PREADY  <= setup;
      O_PSLVERR <= setup & bad_addr;
      O_PRDATA  <= next_prdata;
    end
  end

  // pin synchronisers: stage one feeds only stage two
  logic [`NPIN-1:0] pin_meta;  // first stage, may be metastable
  logic [`NPIN-1:0] pin_s;     // second stage, safe to use
  wire  [`NPIN-1:0] pin_raw = {I_RECEIVE_DATA_PIN, I_TRANSMIT_FRAME_PIN, I_RECEIVE_FRAME_PIN,
                               I_TRANSMIT_CLOCK_PIN, I_RECEIVE_CLOCK_PIN, I_DEDICATED_EXT_CLOCK_PIN};

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end

  // internal input clock: the processor clock divided down, half high
  logic [IW-1:0] int_cnt;  // internal divider phase
  wire  [IW-1:0] next_int = (int_cnt == IW'(INT_DIV - 1)) ? '0 : int_cnt + 1'b1;
  wire           int_lvl  = int_cnt < IW'(INT_DIV / 2);

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      int_cnt <= '0;
    end else begin
      int_cnt <= next_int;
    end
  end

  // input clock selection; the edge select inverts only the dedicated pin
  wire [1:0] src_sel = {cfg.input_clock_pin_select, cfg.input_clock_mode_select};
  wire       ext_lvl = pin_s[`P_EXT] ^ cfg.ext_clock_edge_select;
  wire       src     = (src_sel == `SEL_EXT) ? ext_lvl :
                       (src_sel == `SEL_INT) ? int_lvl :
                       (src_sel == `SEL_RXC) ? pin_s[`P_RXC] : pin_s[`P_TXC];

  // edges of the selected input; a source switch may give one stray edge
  logic src_prev;  // selected input one cycle ago
  wire  tick = src & ~src_prev;  // active edge of the input clock
  wire  fall = ~src & src_prev;  // opposite edge, used only for divide by one

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src;
    end
  end

  // divider state
  logic [7:0] cnt;        // down counter through one bit clock period
  logic       bclk;       // generated bit clock
  logic       fp;         // generated frame pulse
  logic       fs_prev;    // receive frame level at the previous tick
  logic       pend;       // frame request waiting for a period start
  logic [7:0] next_cnt;
  logic       next_bclk;
  logic       next_fp;
  logic       next_fs_prev;
  logic       next_pend;

  wire [7:0] div    = cfg.bit_clock_divide_field;
  wire [7:0] dec    = cnt - 8'h01;
  // high while the count is at or above half the period, rounded down
  wire [8:0] thr9   = ({1'b0, div} + 9'h001) >> 1;
  wire [7:0] thr    = thr9[7:0];
  wire       resync = cfg.frame_resync_enable;
  // frame edge seen only at the tick that also makes the bit clock
  wire       resync_hit = resync & tick & pin_s[`P_RXF] & ~fs_prev;
  // with resync the external frame sets the period, requests are dropped
  wire       req    = I_FRAME_REQ & ~resync;

  // divider next state
  always_comb begin
    next_cnt     = cnt;
    next_bclk    = bclk;
    next_fp      = fp;
    next_fs_prev = fs_prev;
    next_pend    = pend | req;
    if (!cfg.gen_run) begin
      // held in reset: everything low and cleared
      next_cnt     = 8'h00;
      next_bclk    = 1'b0;
      next_fp      = 1'b0;
      next_fs_prev = 1'b0;
      next_pend    = 1'b0;
    end else begin
      if (tick) begin
        next_fs_prev = pin_s[`P_RXF];
      end
      if (resync_hit) begin
        // restart the period, high first, and emit a frame pulse
        next_cnt  = div;
        next_bclk = 1'b1;
        next_fp   = 1'b1;
      end else if (tick && cnt == 8'h00) begin
        // terminal count: preload from the field, new period starts high
        next_cnt  = div;
        next_bclk = 1'b1;
        next_fp   = pend;
        next_pend = req;   // a request in this cycle still counts
      end else if (tick) begin
        // free running count down, no realignment when resync is off
        next_cnt  = dec;
        next_bclk = dec >= thr;
      end else if (fall && div == 8'h00) begin
        // divide by one follows the input, its own duty cycle kept
        next_bclk = 1'b0;
      end
    end
  end

  // divider registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt     <= 8'h00;
      bclk    <= 1'b0;
      fp      <= 1'b0;
      fs_prev <= 1'b0;
      pend    <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      bclk    <= next_bclk;
      fp      <= next_fp;
      fs_prev <= next_fs_prev;
      pend    <= next_pend;
    end
  end

  // loopback is blocked in the clock stop modes
  wire loop_blocked = cfg.loopback_enable & cfg.clock_stop_field[`STOP_BIT];
  wire loop         = cfg.loopback_enable & ~cfg.clock_stop_field[`STOP_BIT];
  // loopback forces transmit clock and frame to be driven
  wire tcm          = cfg.transmit_clock_mode | loop;
  wire tfm          = cfg.transmit_frame_mode | loop;
  wire rcm          = cfg.receive_clock_mode;
  wire rcp          = cfg.receive_clock_polarity;

  // transmit side: generator clock and, if chosen, generator frame
  wire itc = tcm ? bclk : pin_s[`P_TXC];
  wire itf = tfm ? (cfg.transmit_frame_gen_select ? fp : I_TX_FRAME) :
                   pin_s[`P_TXF];
  // receive clock source: transmit clock, bit clock or the pin
  wire irc = loop ? itc :
             rcm  ? bclk :
                    pin_s[`P_RXC] ^ rcp;
  // receive clock pin drive, inverted by polarity
  wire rxc_o = (loop ? itc : bclk) ^ rcp;
  // receive frame pin is an input while resync uses it
  wire rxf_oe = cfg.receive_frame_mode & ~resync;
  wire rxf_i  = loop ? itf :
                cfg.receive_frame_mode ? fp : pin_s[`P_RXF];

  serial_clk_pkg::pins_t pins;       // registered pin and routing state
  serial_clk_pkg::pins_t next_pins;  // routing before its register

  // pin drive and routing, gathered for one register
  always_comb begin
    next_pins.rxc_o   = rxc_o;
    next_pins.rxc_oe  = rcm;
    next_pins.txc_o   = bclk;
    next_pins.txc_oe  = tcm;
    next_pins.txf_o   = itf;
    next_pins.txf_oe  = tfm;
    next_pins.rxf_o   = loop ? itf : fp;
    next_pins.rxf_oe  = rxf_oe;
    next_pins.txd_o   = I_TX_DATA;
    next_pins.irc     = irc;
    next_pins.itc     = itc;
    next_pins.rxf_int = rxf_i;
    next_pins.rxd_int = loop ? I_TX_DATA : pin_s[`P_RXD];
  end

  // routing register, every pin output comes from here
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  // status: count, clock, pulse and loopback state
  assign stat_word = {20'h00000, loop_blocked, loop, fp, bclk, cnt};

  // outputs straight from flops
  assign O_GENERATED_BIT_CLOCK     = bclk;
  assign O_GENERATED_FRAME_PULSE   = fp;
  assign O_RECEIVE_CLOCK_PIN       = pins.rxc_o;
  assign O_RECEIVE_CLOCK_PIN_OE    = pins.rxc_oe;
  assign O_TRANSMIT_CLOCK_PIN      = pins.txc_o;
  assign O_TRANSMIT_CLOCK_PIN_OE   = pins.txc_oe;
  assign O_RECEIVE_FRAME_PIN       = pins.rxf_o;
  assign O_RECEIVE_FRAME_PIN_OE    = pins.rxf_oe;
  assign O_TRANSMIT_FRAME_PIN      = pins.txf_o;
  assign O_TRANSMIT_FRAME_PIN_OE   = pins.txf_oe;
  assign O_TRANSMIT_DATA_PIN       = pins.txd_o;
  assign O_INTERNAL_RECEIVE_CLOCK  = pins.irc;
  assign O_INTERNAL_TRANSMIT_CLOCK = pins.itc;
  assign O_RX_FRAME                = pins.rxf_int;
  assign O_RX_DATA                 = pins.rxd_int;

  // checks on the design's own state
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // a held generator clears its state instead of restarting, so it is left out
  sequence s_resync;
    cfg.gen_run && resync_hit;
  endsequence

  sequence s_high_start;
    bclk && fp && cnt == $past(div);
  endsequence

  chk_resync_start: assert property (s_resync |=> s_high_start)
    else $error("resync did not restart the bit clock high");

  chk_gen_hold: assert property (!cfg.gen_run |=> !bclk && !fp && cnt == 8'h00)
    else $error("generator reset did not hold outputs low");

  chk_reload_term: assert property (cfg.gen_run && tick && cnt == 8'h00 && !resync_hit
                                    |=> bclk && cnt == $past(div))
    else $error("divider did not reload at terminal count");

  chk_duty_level: assert property (cfg.gen_run && tick && cnt != 8'h00 && !resync_hit
                                   |=> bclk == (cnt >= $past(thr)))
    else $error("bit clock level wrong for the count");

  chk_free_run: assert property (!resync && cfg.gen_run && tick && cnt != 8'h00
                                 |=> cnt == $past(dec))
    else $error("divider realigned while resync is off");

  chk_div_one: assert property (cfg.gen_run && div == 8'h00 && fall |=> !bclk)
    else $error("divide by one bit clock did not fall");

  chk_stop_noloop: assert property (cfg.clock_stop_field[`STOP_BIT]
                                    |=> O_RX_DATA == $past(pin_s[`P_RXD]))
    else $error("loopback active in clock stop mode");

  chk_loop_oe: assert property (loop |=> O_TRANSMIT_CLOCK_PIN_OE && O_TRANSMIT_FRAME_PIN_OE)
    else $error("loopback left transmit pins undriven");

  chk_rxclk_hiz: assert property (loop && !rcm
                                  |=> !O_RECEIVE_CLOCK_PIN_OE && O_INTERNAL_RECEIVE_CLOCK == $past(itc))
    else $error("receive clock not from transmit clock with pin released");

  chk_rxclk_drive: assert property (!loop && rcm
                                    |=> O_RECEIVE_CLOCK_PIN_OE && O_RECEIVE_CLOCK_PIN == ($past(bclk) ^ $past(rcp)))
    else $error("receive clock pin not driven from the bit clock");

  chk_apb_ready: assert property (setup |=> O_PREADY ##1 !O_PREADY)
    else $error("apb ready not a single access cycle");

endmodule

// ---- hdl/serial_clk_cfg.svh ----
// constants for the serial port bit clock generator
`ifndef SERIAL_CLK_CFG_SVH
`define SERIAL_CLK_CFG_SVH
// register offsets (byte addresses, one aligned word each)
`define CTRL_OFS    12'h000
`define STAT_OFS    12'h004
// control register reset value, writable mask and used width
`define CTRL_RST    32'h0000_0000
`define CTRL_MASK   32'h003F_FFFF
`define CTRL_W      22
// processor clocks per internal generator input clock period
`define INT_CLK_DIV 6
// generator input clock selection codes {pin select, mode select}
`define SEL_EXT     2'h0
`define SEL_INT     2'h1
`define SEL_RXC     2'h2
// bit of the clock stop field that marks the stop modes 2h and 3h
`define STOP_BIT    1
// synchronised pin vector layout
`define NPIN        6
`define P_EXT       0
`define P_RXC       1
`define P_TXC       2
`define P_RXF       3
`define P_TXF       4
`define P_RXD       5
`endif

// ---- hdl/serial_clk_pkg.sv ----
// types for the serial port bit clock generator
package serial_clk_pkg;
  // control register layout, lsb last
  typedef struct packed {
    logic       gen_run;                   // 21: generator out of reset
    logic       receive_frame_mode;        // 20
    logic       transmit_frame_gen_select; // 19
    logic       transmit_frame_mode;       // 18
    logic       transmit_clock_mode;       // 17
    logic       receive_clock_polarity;    // 16
    logic       receive_clock_mode;        // 15
    logic [1:0] clock_stop_field;          // 14:13
    logic       loopback_enable;           // 12
    logic       frame_resync_enable;       // 11
    logic       ext_clock_edge_select;     // 10
    logic       input_clock_pin_select;    // 9
    logic       input_clock_mode_select;   // 8
    logic [7:0] bit_clock_divide_field;    // 7:0
  } ctrl_t;
  // registered pin drive and internal clock/frame/data routing
  typedef struct packed {
    logic rxc_o;   // receive clock pin level
    logic rxc_oe;  // receive clock pin enable
    logic txc_o;   // transmit clock pin level
    logic txc_oe;  // transmit clock pin enable
    logic rxf_o;   // receive frame pin level
    logic rxf_oe;  // receive frame pin enable
    logic txf_o;   // transmit frame pin level
    logic txf_oe;  // transmit frame pin enable
    logic txd_o;   // transmit data pin level
    logic irc;     // internal receive clock
    logic itc;     // internal transmit clock
    logic rxf_int; // internal receive frame
    logic rxd_int; // internal receive data
  } pins_t;
endpackage

// ---- tb/ser_partner.sv ----
// far side serial device model: free running clock, receive frame and data on the port pins
module ser_partner #(
  parameter int HALF_NS = 70  // half period of the far side clock, slow next to the bench clock
) (
  // pin enables of the design
  input  wire logic i_rxc_oe,
  input  wire logic i_txc_oe,
  input  wire logic i_rxf_oe,
  input  wire logic i_txf_oe,
  // far side drive
  output logic      o_ext_clk,
  output logic      o_rxc,
  output logic      o_txc,
  output logic      o_rxf,
  output logic      o_txf,
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q;  // far side clock
  logic frame;  // far side frame level, active high
  // clock runs free with a fixed phase offset so its edges never meet the bench clock edge
  initial begin
    clk_q = 1'b0;
    frame = 1'b0;
    #3;
    forever #(HALF_NS) clk_q = ~clk_q;
  end
  assign o_ext_clk = clk_q;
  // never fight the design: a pin it drives is released here
  assign o_rxc = i_rxc_oe ? 1'bz : clk_q;
  assign o_txc = i_txc_oe ? 1'bz : clk_q;
  assign o_rxf = i_rxf_oe ? 1'bz : frame;
  assign o_txf = i_txf_oe ? 1'bz : 1'b0;
  assign o_rxd = 1'b0;  // data line held low so loopback data is told apart
  // frame changes on the falling edge so the generating rising edge sees it settled
  task frame_on();
    @(negedge clk_q);
    frame = 1'b1;
  endtask
  // pulse length spans more than one clock, which must not matter
  task frame_off();
    repeat (2) @(negedge clk_q);
    frame = 1'b0;
  endtask
endmodule

// ---- tb/serial_clk_gen_tb.sv ----
// self-checking bench for the serial port bit clock generator
`include "serial_clk_cfg.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
module serial_clk_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;   // short internal input period keeps the run brief
  localparam int EXT = 14;  // far side clock period in bench clocks
  logic                  clk, rst_n, psel, penable, pwrite, tx_data, tx_frame, frame_req, seen;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  pready, pslverr, rxc_o, rxc_oe, txc_o, txc_oe, rxf_o, rxf_oe, txf_o, txf_oe;
  logic                  txd, bclk, fpulse, irc, itc, rx_frame, rx_data;
  wire                   ext_clk, p_rxc, p_txc, p_rxf, p_txf, p_rxd;
  int                    bad_count, cmp_count, n;
  serial_clk_pkg::ctrl_t c;
  int                    divs [6] = '{0, 1, 2, 3, 4, 255};
  logic [3:0]            rt [4] = '{4'h5, 4'h7, 4'h8, 4'hE};  // {loopback, rx mode, polarity, tx mode}
  // pin levels worked out from whoever enables its driver
  wire rxc_line = rxc_oe ? rxc_o : p_rxc;
  wire txc_line = txc_oe ? txc_o : p_txc;
  wire rxf_line = rxf_oe ? rxf_o : p_rxf;
  wire txf_line = txf_oe ? txf_o : p_txf;
  serial_clk_gen #(.INT_DIV(DIV)) u_serial_clk_gen (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PREADY(pready), .O_PRDATA(prdata),
    .O_PSLVERR(pslverr), .I_DEDICATED_EXT_CLOCK_PIN(ext_clk), .I_RECEIVE_CLOCK_PIN(rxc_line),
    .O_RECEIVE_CLOCK_PIN(rxc_o), .O_RECEIVE_CLOCK_PIN_OE(rxc_oe), .I_TRANSMIT_CLOCK_PIN(txc_line),
    .O_TRANSMIT_CLOCK_PIN(txc_o), .O_TRANSMIT_CLOCK_PIN_OE(txc_oe), .I_RECEIVE_FRAME_PIN(rxf_line),
    .O_RECEIVE_FRAME_PIN(rxf_o), .O_RECEIVE_FRAME_PIN_OE(rxf_oe), .I_TRANSMIT_FRAME_PIN(txf_line),
    .O_TRANSMIT_FRAME_PIN(txf_o), .O_TRANSMIT_FRAME_PIN_OE(txf_oe), .I_RECEIVE_DATA_PIN(p_rxd),
    .O_TRANSMIT_DATA_PIN(txd), .I_TX_DATA(tx_data), .I_TX_FRAME(tx_frame), .I_FRAME_REQ(frame_req),
    .O_GENERATED_BIT_CLOCK(bclk), .O_GENERATED_FRAME_PULSE(fpulse), .O_INTERNAL_RECEIVE_CLOCK(irc),
    .O_INTERNAL_TRANSMIT_CLOCK(itc), .O_RX_FRAME(rx_frame), .O_RX_DATA(rx_data));
  ser_partner #(.HALF_NS(70)) u_ser_partner (
    .i_rxc_oe(rxc_oe), .i_txc_oe(txc_oe), .i_rxf_oe(rxf_oe), .i_txf_oe(txf_oe), .o_ext_clk(ext_clk),
    .o_rxc(p_rxc), .o_txc(p_txc), .o_rxf(p_rxf), .o_txf(p_txf), .o_rxd(p_rxd));
  // bench clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one apb transfer: setup, then access held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    `CHK("pslverr", err, pslverr)
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wcfg();
    apb(1'b1, `CTRL_OFS, 32'(c), 1'b0);
  endtask
  // wait, bounded, for the next rising bit clock
  task rise();
    for (n = 0; n < 3000 && bclk !== 1'b0; n++) @(posedge clk);
    for (n = 0; n < 3000 && bclk !== 1'b1; n++) @(posedge clk);
  endtask
  // skip one period so a new divide value has loaded, then time high and low phases
  task meas(input int hi, input int lo);
    rise();
    rise();
    for (n = 0; n < 3000 && bclk === 1'b1; n++) @(posedge clk);
    `CHK("high", hi, n)
    for (n = 0; n < 3000 && bclk === 1'b0; n++) @(posedge clk);
    `CHK("low", lo, n)
  endtask
  // optional frame request, then watch the frame pulse for a while
  task watch(input logic fr, input logic exp);
    @(posedge clk);
    frame_req <= fr;
    @(posedge clk);
    frame_req <= 1'b0;
    seen = 1'b0;
    repeat (80) begin
      @(posedge clk);
      seen = seen | fpulse;
    end
    `CHK("fpulse", exp, seen)
  endtask
  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the expected run of about 7k cycles
  initial begin
    #600000;
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, tx_data, tx_frame, frame_req} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("rst", 6'h00, {bclk, fpulse, rxc_oe, txc_oe, rxf_oe, txf_oe})
    apb(1'b0, `CTRL_OFS, '0, 1'b0);
    `CHK("ctrl", `CTRL_RST, rd)
    apb(1'b1, `CTRL_OFS, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, `CTRL_OFS, '0, 1'b0);
    `CHK("mask", `CTRL_MASK, rd)
    apb(1'b1, `STAT_OFS, '0, 1'b1);
    apb(1'b0, 12'h008, '0, 1'b1);
    // divide ratios from the internal input clock, boundary 255 included
    foreach (divs[i]) begin
      c = '0;
      c.gen_run = 1'b1;
      c.input_clock_mode_select = 1'b1;
      c.bit_clock_divide_field = divs[i][7:0];
      wcfg();
      if (divs[i] == 0) meas(DIV / 2, DIV / 2);
      else meas((divs[i] / 2 + 1) * DIV, (divs[i] - divs[i] / 2) * DIV);
    end
    // all four input clock sources
    for (int s = 0; s < 4; s++) begin
      c = '0;
      c.gen_run = 1'b1;
      c.bit_clock_divide_field = 8'h01;
      {c.input_clock_pin_select, c.input_clock_mode_select} = 2'(s);
      wcfg();
      if (s == 1) meas(DIV, DIV);
      else meas(EXT, EXT);
    end
    // edge select of the dedicated clock: pin level just after the bit clock rises
    for (int e = 0; e < 2; e++) begin
      c.input_clock_pin_select = 1'b0;
      c.input_clock_mode_select = 1'b0;
      c.ext_clock_edge_select = e[0];
      wcfg();
      meas(EXT, EXT);
      rise();
      `CHK("edge", ~c.ext_clock_edge_select, ext_clk)
    end
    // frame edge in the low phase restarts the divider high, long before the natural rise
    c = '0;
    c.gen_run = 1'b1;
    c.bit_clock_divide_field = 8'h03;
    c.frame_resync_enable = 1'b1;
    wcfg();
    rise();
    for (n = 0; n < 3000 && bclk !== 1'b0; n++) @(posedge clk);
    u_ser_partner.frame_on();
    for (n = 0; n < 30 && bclk !== 1'b1; n++) @(posedge clk);
    `CHK("resync", 1'b1, n < 20)
    `CHK("fpulse", 1'b1, fpulse)
    for (n = 0; n < 3000 && bclk === 1'b1; n++) @(posedge clk);
    `CHK("rehigh", 2 * EXT, n)
    u_ser_partner.frame_off();
    // let the resync pulse end at the next period start before watching for a stray one
    rise();
    watch(1'b1, 1'b0);
    c.frame_resync_enable = 1'b0;
    wcfg();
    u_ser_partner.frame_on();
    watch(1'b0, 1'b0);
    u_ser_partner.frame_off();
    watch(1'b1, 1'b1);
    // receive clock routing and loopback, transmitter data and frame held high
    tx_data <= 1'b1;
    tx_frame <= 1'b1;
    foreach (rt[i]) begin
      c = '0;
      c.gen_run = 1'b1;
      c.input_clock_mode_select = 1'b1;
      c.bit_clock_divide_field = 8'h01;
      {c.loopback_enable, c.receive_clock_mode, c.receive_clock_polarity, c.transmit_clock_mode} = rt[i];
      wcfg();
      repeat (6) @(posedge clk);
      repeat (8) begin
        @(posedge clk);
        `CHK("rxc_oe", c.receive_clock_mode, rxc_oe)
        if (c.receive_clock_mode) `CHK("rxc", itc ^ c.receive_clock_polarity, rxc_o)
        if (!c.receive_clock_polarity) `CHK("irc", itc, irc)
        `CHK("txc_oe", 1'b1, txc_oe)
        `CHK("txf_oe", c.loopback_enable, txf_oe)
        `CHK("rxd", c.loopback_enable, rx_data)
        `CHK("rxf", c.loopback_enable, rx_frame)
        `CHK("txd", 1'b1, txd)
        `CHK("txc", itc, txc_o)
        `CHK("txf", c.loopback_enable, txf_o)
        if (c.loopback_enable) `CHK("rxf_pin", 1'b1, rxf_o)
      end
    end
    // receive clock pin as input, with and without inversion
    for (int p = 0; p < 2; p++) begin
      c = '0;
      c.gen_run = 1'b1;
      c.receive_clock_polarity = p[0];
      wcfg();
      @(posedge ext_clk);
      repeat (5) @(posedge clk);
      `CHK("irc_hi", ~c.receive_clock_polarity, irc)
      @(negedge ext_clk);
      repeat (5) @(posedge clk);
      `CHK("irc_lo", c.receive_clock_polarity, irc)
    end
    // loopback blocked in the clock stop modes
    for (int s = 0; s < 4; s++) begin
      c = '0;
      c.gen_run = 1'b1;
      c.loopback_enable = 1'b1;
      c.clock_stop_field = 2'(s);
      wcfg();
      repeat (6) @(posedge clk);
      `CHK("rxd", ~c.clock_stop_field[1], rx_data)
      apb(1'b0, `STAT_OFS, '0, 1'b0);
      `CHK("lb_stat", {c.clock_stop_field[1], ~c.clock_stop_field[1]}, rd[11:10])
    end
    // generator held in reset mid-run
    c.gen_run = 1'b0;
    wcfg();
    repeat (4) @(posedge clk);
    `CHK("held", 2'b00, {bclk, fpulse})
    apb(1'b0, `STAT_OFS, '0, 1'b0);
    `CHK("cnt", 10'h000, rd[9:0])
    results();
  end
endmodule
